// >>> verilog/asx_expander.sv
// Addressed serial port expander, device side
// Behaviour
// - In reset, port drivers off and serial_out high with pull-down off.
// - Access runs from select fall to select rise; respond only while low.
// - At select fall capture the eight port pin levels for output.
// - Clock rises 1-16 in access shift serial_in; rises are counted up to 255.
// - serial_out goes low only on clock falls; high unless acknowledging or shifting data.
// - Frame is 16 bits: address and command, then data byte.
// - After five address bits compare with strap; act only on match.
// - Strap input reads 1 when tied high, 0 when tied low.
// - On match drive acknowledge low at eighth clock fall; else stay high.
// - Match with command not all ones: serial_out high at ninth rise.
// - Match and all ones: shift captured byte out, top pin first, falls 9-16.
// - Beyond sixteen edges only the counter keeps counting.
// - At select rise serial_out high; latch data only if count is 16.
// - Count not 16 at select rise: latch kept, counter cleared, ready again.
// - Counter cleared at every select rise.
// - Port pins driven with inverted data; sampled levels returned uninverted.
// - Pin driving low is an input with pull-down; write 1 for input.
`include "asx_params.svh"
module asx_expander #(
  parameter int ADDR_BITS = `ASX_ADDR_BITS,
  parameter int PORT_BITS = `ASX_PORT_BITS
) (
  input  wire logic                 mclk,
  input  wire logic                 arst_n,
  input  wire logic                 access_select_n,
  input  wire logic                 serial_clk,
  input  wire logic                 serial_in,
  input  wire logic [ADDR_BITS-1:0] addr_strap,
  input  wire logic [PORT_BITS-1:0] port_pins_in,
  output logic      [PORT_BITS-1:0] port_pins_out,
  output logic      [PORT_BITS-1:0] port_pins_oe,
  output logic                      serial_out,
  output logic                      serial_out_oe
);

  // ***********************************************
  // Input synchronisers
  // ***********************************************
  logic                 sel_s1_ff;
  logic                 sel_s2_ff;
  logic                 sel_d_ff;
  logic                 clk_s1_ff;
  logic                 clk_s2_ff;
  logic                 clk_d_ff;
  logic                 din_s1_ff;
  logic                 din_s2_ff;
  logic [ADDR_BITS-1:0] strap_s1_ff;
  logic [ADDR_BITS-1:0] strap_s2_ff;
  logic [PORT_BITS-1:0] pin_s1_ff;
  logic [PORT_BITS-1:0] pin_s2_ff;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sel_s1_ff   <= 1'b1;
      sel_s2_ff   <= 1'b1;
      sel_d_ff    <= 1'b1;
      clk_s1_ff   <= 1'b0;
      clk_s2_ff   <= 1'b0;
      clk_d_ff    <= 1'b0;
      din_s1_ff   <= 1'b1;
      din_s2_ff   <= 1'b1;
      strap_s1_ff <= '0;
      strap_s2_ff <= '0;
      pin_s1_ff   <= '0;
      pin_s2_ff   <= '0;
    end else begin
      sel_s1_ff   <= access_select_n;
      sel_s2_ff   <= sel_s1_ff;
      sel_d_ff    <= sel_s2_ff;
      clk_s1_ff   <= serial_clk;
      clk_s2_ff   <= clk_s1_ff;
      clk_d_ff    <= clk_s2_ff;
      din_s1_ff   <= serial_in;
      din_s2_ff   <= din_s1_ff;
      strap_s1_ff <= addr_strap;
      strap_s2_ff <= strap_s1_ff;
      pin_s1_ff   <= port_pins_in;
      pin_s2_ff   <= pin_s1_ff;
    end
  end

  // ***********************************************
  // Edge detection
  // ***********************************************
  logic sel_fall;
  logic sel_rise;
  logic active;
  logic clk_rise;
  logic clk_fall;

  assign active   = !sel_s2_ff && !sel_d_ff;
  assign sel_fall = !sel_s2_ff && sel_d_ff;
  assign sel_rise = sel_s2_ff && !sel_d_ff;
  assign clk_rise = active && clk_s2_ff && !clk_d_ff;
  assign clk_fall = active && !clk_s2_ff && clk_d_ff;

  // ***********************************************
  // Counter and input shift register
  // ***********************************************
  logic [`ASX_CNT_BITS-1:0] cnt_ff;
  logic [15:0]              rx_ff;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= '0;
    end else if (sel_rise || sel_fall) begin
      cnt_ff <= '0;
    end else if (clk_rise && cnt_ff != `ASX_CNT_MAX) begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rx_ff <= '0;
    end else if (clk_rise && cnt_ff < `ASX_CNT_LAST) begin
      rx_ff <= {rx_ff[14:0], din_s2_ff};
    end
  end

  // ***********************************************
  // Address and command decode
  // ***********************************************
  logic addr_match_ff;
  logic cmd_ok_ff;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      addr_match_ff <= 1'b0;
    end else if (sel_fall) begin
      addr_match_ff <= 1'b0;
    end else if (clk_rise && cnt_ff == `ASX_CNT_ADDR) begin
      addr_match_ff <= (rx_ff[4:0] == strap_s2_ff);
    end
  end

  // Command field decode, used by several blocks
  function automatic logic cmd_all_ones(input logic [2:0] cmd);
    return (cmd == 3'h7);
  endfunction

  // command bits are frame bits 6..8
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_ok_ff <= 1'b0;
    end else if (sel_fall) begin
      cmd_ok_ff <= 1'b0;
    end else if (clk_rise && cnt_ff == `ASX_CNT_CMD) begin
      cmd_ok_ff <= cmd_all_ones(rx_ff[2:0]);
    end
  end

  // ***********************************************
  // Serial output sequencer
  // ***********************************************
  asx_pkg::asx_state_type   state_ff;
  logic [PORT_BITS-1:0]     tx_ff;
  logic                     so_ff;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tx_ff <= '0;
    end else if (sel_fall) begin
      tx_ff <= pin_s2_ff;
    end else if (clk_fall && state_ff == asx_pkg::ASX_SHIFT) begin
      tx_ff <= {tx_ff[PORT_BITS-2:0], 1'b0};
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= asx_pkg::ASX_IDLE;
    end else if (sel_rise || sel_fall) begin
      state_ff <= asx_pkg::ASX_IDLE;
    end else begin
      case (state_ff)
        asx_pkg::ASX_IDLE: begin
          if (clk_rise && cnt_ff == `ASX_CNT_CMD && addr_match_ff) begin
            state_ff <= cmd_all_ones(rx_ff[2:0]) ? asx_pkg::ASX_SHIFT
                                                 : asx_pkg::ASX_HALT;
          end
        end
        asx_pkg::ASX_SHIFT: begin
          if (clk_rise && cnt_ff == `ASX_CNT_LAST) begin
            state_ff <= asx_pkg::ASX_HALT;
          end
        end
        asx_pkg::ASX_HALT: state_ff <= asx_pkg::ASX_HALT;
        default:           state_ff <= asx_pkg::ASX_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      so_ff <= 1'b1;
    end else if (sel_rise || sel_fall) begin
      so_ff <= 1'b1;
    // forced high at ninth rise on bad command
    end else if (clk_rise && cnt_ff == `ASX_CNT_CMD
                 && addr_match_ff && !cmd_all_ones(rx_ff[2:0])) begin
      so_ff <= 1'b1;
    end else if (clk_fall && cnt_ff == `ASX_CNT_ACK && addr_match_ff) begin
      so_ff <= 1'b0;
    end else if (clk_fall && state_ff == asx_pkg::ASX_SHIFT) begin
      so_ff <= tx_ff[PORT_BITS-1];
    end else if (clk_fall) begin
      so_ff <= 1'b1;
    end
  end

  assign serial_out    = so_ff;
  assign serial_out_oe = !so_ff;

  // ***********************************************
  // Output latch
  // ***********************************************
  logic [PORT_BITS-1:0] latch_ff;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      latch_ff <= `ASX_LATCH_RST;
    // latch only on full valid frame
    end else if (sel_rise && cnt_ff == `ASX_CNT_FULL
                 && addr_match_ff && cmd_ok_ff) begin
      latch_ff <= rx_ff[PORT_BITS-1:0];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < PORT_BITS; gi++) begin : g_pin
      assign port_pins_out[gi] = !latch_ff[gi];
      assign port_pins_oe[gi]  = !latch_ff[gi];
    end
  endgenerate

  // ***********************************************
  // Checks
  // ***********************************************
  sequence s_sel_rise_full;
    sel_rise && cnt_ff == `ASX_CNT_FULL && addr_match_ff && cmd_ok_ff;
  endsequence

  sequence s_sel_rise_short;
    sel_rise && cnt_ff != `ASX_CNT_FULL;
  endsequence

  sequence s_ack_fall;
    clk_fall && cnt_ff == `ASX_CNT_ACK && addr_match_ff;
  endsequence

  sequence s_bad_cmd_rise;
    clk_rise && cnt_ff == `ASX_CNT_CMD && addr_match_ff
    && !cmd_all_ones(rx_ff[2:0]);
  endsequence

  reset_drive_a: assert property (@(posedge mclk)
    !arst_n |=> serial_out && !serial_out_oe)
    else $error("serial_out not idle in reset");

  pins_off_reset_a: assert property (@(posedge mclk)
    !arst_n |=> port_pins_oe == '0)
    else $error("port drivers on in reset");

  idle_high_a: assert property (@(posedge mclk) disable iff (!arst_n)
    sel_s2_ff && sel_d_ff |-> serial_out && !serial_out_oe)
    else $error("serial_out low outside access");

  pin_capture_a: assert property (@(posedge mclk) disable iff (!arst_n)
    sel_fall |=> tx_ff == $past(pin_s2_ff))
    else $error("port pins not captured");

  count_step_a: assert property (@(posedge mclk) disable iff (!arst_n)
    clk_rise && cnt_ff != `ASX_CNT_MAX |=> cnt_ff == $past(cnt_ff) + 8'h01)
    else $error("clock edge not counted");

  rx_freeze_a: assert property (@(posedge mclk) disable iff (!arst_n)
    clk_rise && cnt_ff >= `ASX_CNT_LAST |=> $stable(rx_ff))
    else $error("shift register moved past sixteen");

  latch_guard_a: assert property (@(posedge mclk) disable iff (!arst_n)
    sel_rise && !(addr_match_ff && cmd_ok_ff) |=> $stable(port_pins_out))
    else $error("latch changed without valid command");

  latch_load_a: assert property (@(posedge mclk) disable iff (!arst_n)
    s_sel_rise_full |=> port_pins_out == ~$past(rx_ff[PORT_BITS-1:0]))
    else $error("latch not loaded on full frame");

  latch_keep_a: assert property (@(posedge mclk) disable iff (!arst_n)
    s_sel_rise_short |=> $stable(port_pins_out) && cnt_ff == 8'h00)
    else $error("latch changed on short frame");

  count_clear_a: assert property (@(posedge mclk) disable iff (!arst_n)
    sel_rise |=> cnt_ff == 8'h00)
    else $error("counter not cleared");

  out_high_rise_a: assert property (@(posedge mclk) disable iff (!arst_n)
    sel_rise |=> serial_out)
    else $error("serial_out not high after select rise");

  fall_only_a: assert property (@(posedge mclk) disable iff (!arst_n)
    $fell(serial_out) |-> $past(clk_fall))
    else $error("serial_out fell off a clock fall");

  ack_low_a: assert property (@(posedge mclk) disable iff (!arst_n)
    s_ack_fall |=> !serial_out)
    else $error("acknowledge missing");

  no_match_a: assert property (@(posedge mclk) disable iff (!arst_n)
    !addr_match_ff && state_ff == asx_pkg::ASX_IDLE |-> serial_out)
    else $error("serial_out low without match");

  bad_cmd_a: assert property (@(posedge mclk) disable iff (!arst_n)
    state_ff == asx_pkg::ASX_HALT && cnt_ff < `ASX_CNT_LAST |-> serial_out)
    else $error("serial_out low after bad command");

  bad_cmd_halt_a: assert property (@(posedge mclk) disable iff (!arst_n)
    s_bad_cmd_rise |=> serial_out && state_ff == asx_pkg::ASX_HALT)
    else $error("bad command did not halt");

  shift_data_a: assert property (@(posedge mclk) disable iff (!arst_n)
    clk_fall && state_ff == asx_pkg::ASX_SHIFT
    |=> serial_out == $past(tx_ff[PORT_BITS-1]))
    else $error("wrong shifted data bit");

  pin_invert_a: assert property (@(posedge mclk) disable iff (!arst_n)
    port_pins_out == ~latch_ff && port_pins_oe == ~latch_ff)
    else $error("port drive not inverted");

endmodule

// >>> verilog/asx_params.svh
// Constants for the addressed serial port expander
`ifndef ASX_PARAMS_SVH
`define ASX_PARAMS_SVH
`define ASX_ADDR_BITS   5
`define ASX_PORT_BITS   8
`define ASX_CNT_BITS    8
`define ASX_CNT_ADDR    8'h05
`define ASX_CNT_ACK     8'h08
`define ASX_CNT_CMD     8'h08
`define ASX_CNT_LAST    8'h10
`define ASX_CNT_FULL    8'h10
`define ASX_CNT_MAX     8'hFF
`define ASX_LATCH_RST   8'hFF
`endif

// >>> verilog/asx_pkg.sv
// Types for the addressed serial port expander
package asx_pkg;
  typedef enum logic [1:0] {
    ASX_IDLE,
    ASX_SHIFT,
    ASX_HALT
  } asx_state_type;
endpackage

// >>> testbench/asx_host_model.sv
// Host model driving select, link clock and serial data
module asx_host_model (
  input  wire logic mclk,
  input  wire logic serial_line,
  output logic      access_select_n,
  output logic      serial_clk,
  output logic      serial_in
);
  timeunit 1ns;
  timeprecision 100ps;

  // ****************
  // Idle levels
  // ****************
  initial begin
    access_select_n = 1'b1;
    serial_clk      = 1'b0;
    serial_in       = 1'b1;
  end

  // ****************
  // One access frame
  // ****************
  // select framing, 16 bits MSB first
  task automatic frame(input logic [15:0] word, input int nclk,
                       output logic [15:0] rx);
    rx = 16'hFFFF;
    @(negedge mclk) access_select_n = 1'b0;
    for (int k = 1; k <= nclk + 1; k++) begin
      repeat (2) @(negedge mclk);
      serial_in = (k <= 16) ? word[16-k] : 1'b1;
      repeat (3) @(negedge mclk);
      if (k > 1 && k <= 17) rx[17-k] = serial_line;
      if (k <= nclk) begin
        serial_clk = 1'b1;
        repeat (3) @(negedge mclk);
        serial_clk = 1'b0;
      end
    end
    access_select_n = 1'b1;
    serial_in       = 1'b1;
    repeat (8) @(negedge mclk);
  endtask
endmodule

// >>> testbench/tb_addressed_serial_port_expander.sv
// Self-checking bench for the addressed serial port expander
module tb_addressed_serial_port_expander;
  timeunit 1ns;
  timeprecision 100ps;

  // ****************
  // Signals
  // ****************
  logic        mclk;
  logic        arst_n;
  logic        sel_n;
  logic        sclk;
  logic        sdin;
  logic        so_oe;
  logic        so_val;
  logic        sline;
  logic [4:0]  strap;
  logic [7:0]  ext_val;
  logic [7:0]  pins_in;
  logic [7:0]  port_pins_out;
  logic [7:0]  port_pins_oe;
  logic [15:0] rx;
  int          n_fail = 0;
  int          num_checks = 0;

  always #5 mclk = ~mclk;
  // Open-drain line with pull-up, undriven pins read ext_val
  assign sline   = so_oe ? 1'b0 : 1'b1;
  assign pins_in = (port_pins_oe & port_pins_out) | (~port_pins_oe & ext_val);

  asx_expander DUT (
    .mclk            (mclk),
    .arst_n          (arst_n),
    .access_select_n (sel_n),
    .serial_clk      (sclk),
    .serial_in       (sdin),
    .addr_strap      (strap),
    .port_pins_in    (pins_in),
    .port_pins_out   (port_pins_out),
    .port_pins_oe    (port_pins_oe),
    .serial_out      (so_val),
    .serial_out_oe   (so_oe)
  );

  asx_host_model host (
    .mclk            (mclk),
    .serial_line     (sline),
    .access_select_n (sel_n),
    .serial_clk      (sclk),
    .serial_in       (sdin)
  );

  // ****************
  // Checks and verdict
  // ****************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    if (n_fail == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ****************
  // Scenarios
  // ****************
  task automatic t_reset;
    chk(sline, 1'b1);
    chk(so_val, 1'b1);
    chk(port_pins_oe, 8'h00);
  endtask

  task automatic t_write;
    ext_val = 8'hA5;
    host.frame({strap, 3'b111, 8'h3C}, 16, rx);
    chk(rx, 16'hFEA5);
    chk(sline, 1'b1);
    chk(so_val, 1'b1);
    chk(port_pins_oe, 8'hC3);
    chk(port_pins_out & port_pins_oe, 8'hC3);
    ext_val = 8'h14;
    host.frame({strap, 3'b111, 8'hFF}, 16, rx);
    chk(rx, 16'hFED7);
    chk(port_pins_oe, 8'h00);
  endtask

  task automatic t_mismatch;
    host.frame({strap ^ 5'h01, 3'b111, 8'h00}, 16, rx);
    chk(rx, 16'hFFFF);
    chk(port_pins_oe, 8'h00);
    strap = 5'h0C;
    host.frame({5'h0C, 3'b111, 8'hFF}, 16, rx);
    chk(rx, 16'hFE14);
  endtask

  task automatic t_badcmd;
    for (int c = 0; c < 7; c++) begin
      host.frame({strap, c[2:0], 8'h00}, 16, rx);
      chk(rx, 16'hFEFF);
      chk(port_pins_oe, 8'h00);
    end
  endtask

  task automatic t_count;
    ext_val = 8'h5A;
    host.frame({strap, 3'b111, 8'h00}, 15, rx);
    chk(rx, 16'hFE5B);
    chk(port_pins_oe, 8'h00);
    host.frame({strap, 3'b111, 8'h00}, 17, rx);
    chk(rx, 16'hFE5A);
    chk(port_pins_oe, 8'h00);
    host.frame({strap, 3'b111, 8'h0F}, 16, rx);
    chk(port_pins_oe, 8'hF0);
  endtask

  // ****************
  // Main sequence
  // ****************
  initial begin
    mclk    = 1'b0;
    arst_n  = 1'b0;
    strap   = 5'h13;
    ext_val = 8'h00;
    repeat (4) @(negedge mclk);
    t_reset;
    repeat (4) @(negedge mclk);
    arst_n = 1'b1;
    repeat (3) @(negedge mclk);
    t_write;
    t_mismatch;
    t_badcmd;
    t_count;
    test_done;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    test_done;
  end
endmodule
